// >>> rtl/iww_ctrl.sv
// Idle-mode entry, wake-up and watchdog control
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

module iww_ctrl #(
	parameter int PORT_W = 8,
	parameter int IRQ_W = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Core commands
	input wire iww_pkg::iww_cmd_s cmd,
	input wire logic deep_sleep_req,
	input wire logic [IRQ_W-1:0] irq_req,
	input wire logic [IRQ_W-1:0] irq_enable,
	input wire logic stack_full,
	// Clock sources
	input wire logic sys_tick,
	input wire logic sub_tick,
	input wire logic high_osc_needed,
	input wire logic low_osc_needed,
	// Pins
	input wire logic [PORT_W-1:0] porta_pin,
	input wire logic ext_reset_pin_b,
	// Results to core
	output iww_pkg::iww_clk_s clk_ctl,
	output logic full_reset,
	output logic pc_sp_reset,
	output logic [IRQ_W-1:0] irq_service,
	output logic [IRQ_W-1:0] irq_pending,
	output logic resume_next
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] wdog_ctrl_q;
	logic [7:0] sys_mode_q;
	logic [PORT_W-1:0] wake_en_q;
	logic [7:0] config_q;
	logic pdf_q;
	logic to_q;
	logic clr_last_two_q;
	logic clr_seen_q;
	iww_pkg::iww_state_e state_q;
	iww_pkg::iww_state_e state_d;

	wire wr_wdog = reg_wr && (reg_addr == iww_pkg::ADDR_WDOG_CTRL);
	wire wr_mode = reg_wr && (reg_addr == iww_pkg::ADDR_SYS_MODE);
	wire wr_wake = reg_wr && (reg_addr == iww_pkg::ADDR_WAKE_EN);
	wire wr_cfg = reg_wr && (reg_addr == iww_pkg::ADDR_CONFIG);

	wire sysclk_keep = wdog_ctrl_q[iww_pkg::SYSCLK_KEEP_BIT];
	wire [2:0] tsel = wdog_ctrl_q[iww_pkg::TSEL_LSB +: 3];
	wire [3:0] soft_en = wdog_ctrl_q[iww_pkg::SOFT_EN_LSB +: 4];
	wire idle_sel = sys_mode_q[iww_pkg::IDLE_SEL_BIT];
	wire cfg_dis = config_q[iww_pkg::CFG_WDT_DIS_BIT];
	wire cfg_src_sub = config_q[iww_pkg::CFG_SRC_SUB_BIT];
	wire cfg_two_clr = config_q[iww_pkg::CFG_TWO_CLR_BIT];

	// Disabled only when both configuration and soft field agree
	wire wdt_on = !(cfg_dis && (soft_en == iww_pkg::SOFT_DISABLE_CODE));

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [PORT_W-1:0] pa_s1_q;
	logic [PORT_W-1:0] pa_s2_q;
	logic [PORT_W-1:0] pa_s3_q;
	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_s3_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pa_s1_q <= '1;
			pa_s2_q <= '1;
			pa_s3_q <= '1;
			rst_s1_q <= 1'b1;
			rst_s2_q <= 1'b1;
			rst_s3_q <= 1'b1;
		end else begin
			pa_s1_q <= porta_pin;
			pa_s2_q <= pa_s1_q;
			pa_s3_q <= pa_s2_q;
			rst_s1_q <= ext_reset_pin_b;
			rst_s2_q <= rst_s1_q;
			rst_s3_q <= rst_s2_q;
		end
	end

	wire [PORT_W-1:0] pa_fall = pa_s3_q & ~pa_s2_q;
	wire ext_rst_fall = rst_s3_q && !rst_s2_q;

	// ----------------------------------------
	// Commands and watchdog
	// ----------------------------------------
	wire in_idle = (state_q == iww_pkg::IWW_IDLE_OFF) || (state_q == iww_pkg::IWW_IDLE_ON);
	wire in_sleep = in_idle || (state_q == iww_pkg::IWW_START);
	wire running = (state_q == iww_pkg::IWW_RUN);
	wire halt_go = running && cmd.halt;

	// Two-instruction mode: only an alternating clear counts
	wire clr_alt = (cmd.clr_one && (!clr_seen_q || clr_last_two_q))
		|| (cmd.clr_two && (!clr_seen_q || !clr_last_two_q));
	wire clr_ok = wdt_on && running && (cfg_two_clr ? clr_alt : cmd.clr_single);

	// Sysclk/4 divider; the quarter tick counts only while the system clock is live (IWW_RUN or IWW_IDLE_ON)
	logic [1:0] div_q;
	wire sys_quarter = sys_tick && (div_q == 2'(iww_pkg::SYS_DIV - 1));
	wire sys_clk_live = running || (state_q == iww_pkg::IWW_IDLE_ON);
	wire wdt_tick = wdt_on && (cfg_src_sub ? sub_tick : (sys_quarter && sys_clk_live));
	wire wdt_clear = !wdt_on || clr_ok || halt_go || ext_rst_fall;
	logic wdt_ovf;

	iww_wdog_cnt #(
		.CW(iww_pkg::CNT_W)
	) u_cnt (
		.mclk(mclk),
		.rst_b(rst_b),
		.tick(wdt_tick),
		.clear(wdt_clear),
		.tsel(tsel),
		.ovf(wdt_ovf)
	);

	// ----------------------------------------
	// Wake logic
	// ----------------------------------------
	logic [IRQ_W-1:0] irq_armed_q;
	wire [IRQ_W-1:0] irq_wake = irq_req & irq_armed_q;
	wire port_wake = |(pa_fall & wake_en_q);
	wire any_wake = ext_rst_fall || port_wake || (|irq_wake) || wdt_ovf;
	wire [IRQ_W-1:0] can_serve = stack_full ? '0 : (irq_req & irq_enable);

	// Shared startup timer: high crystal first, then low crystal
	logic [10:0] sst_q;
	logic sst_low_q;
	logic high_rdy_q;
	logic low_rdy_q;
	wire sst_done = (sst_q == 11'(iww_pkg::STARTUP_CYCLES - 1));

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			iww_pkg::IWW_RUN: begin
				if (halt_go && idle_sel) begin
					state_d = sysclk_keep ? iww_pkg::IWW_IDLE_ON : iww_pkg::IWW_IDLE_OFF;
				end else if (halt_go) begin
					state_d = iww_pkg::IWW_IDLE_OFF;
				end
			end
			iww_pkg::IWW_IDLE_OFF, iww_pkg::IWW_IDLE_ON: begin
				if (any_wake) begin
					state_d = (deep_sleep_req && high_osc_needed) ? iww_pkg::IWW_START : iww_pkg::IWW_RUN;
				end
			end
			iww_pkg::IWW_START: begin
				if (high_rdy_q) begin
					state_d = iww_pkg::IWW_RUN;
				end
			end
		endcase
	end

	// ----------------------------------------
	// State and flags
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= iww_pkg::IWW_RUN;
			div_q <= '0;
			pdf_q <= 1'b0;
			to_q <= 1'b0;
			clr_seen_q <= 1'b0;
			clr_last_two_q <= 1'b0;
			irq_armed_q <= '0;
		end else begin
			state_q <= state_d;
			if (sys_tick) begin
				div_q <= div_q + 2'd1;
			end
			// Hardware set wins over clear in the same cycle
			if (halt_go) begin
				pdf_q <= 1'b1;
			end else if (clr_ok || ext_rst_fall) begin
				pdf_q <= 1'b0;
			end
			if (wdt_ovf) begin
				to_q <= 1'b1;
			end else if (halt_go || clr_ok || ext_rst_fall) begin
				to_q <= 1'b0;
			end
			if (clr_ok && cfg_two_clr) begin
				clr_seen_q <= 1'b1;
				clr_last_two_q <= cmd.clr_two;
			end
			if (halt_go) begin
				irq_armed_q <= ~irq_req;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sst_q <= '0;
			sst_low_q <= 1'b0;
			high_rdy_q <= 1'b1;
			low_rdy_q <= 1'b1;
		end else if (state_q == iww_pkg::IWW_START && !high_rdy_q) begin
			sst_q <= sst_done ? '0 : sst_q + 11'd1;
			high_rdy_q <= sst_done;
			sst_low_q <= sst_done && low_osc_needed;
		end else if (sst_low_q) begin
			sst_q <= sst_done ? '0 : sst_q + 11'd1;
			low_rdy_q <= sst_done;
			sst_low_q <= !sst_done;
		end else if (in_idle && any_wake && deep_sleep_req && high_osc_needed) begin
			high_rdy_q <= 1'b0;
			low_rdy_q <= !low_osc_needed;
		end
	end

	// ----------------------------------------
	// Software registers; writes held off while halted
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wdog_ctrl_q <= iww_pkg::WDOG_CTRL_RST;
			sys_mode_q <= iww_pkg::SYS_MODE_RST;
			wake_en_q <= PORT_W'(iww_pkg::WAKE_EN_RST);
			config_q <= iww_pkg::CONFIG_RST;
		end else if (!in_sleep) begin
			if (wr_wdog) begin
				wdog_ctrl_q <= reg_wdata;
			end
			if (wr_mode) begin
				sys_mode_q <= reg_wdata;
			end
			if (wr_wake) begin
				wake_en_q <= reg_wdata[PORT_W-1:0];
			end
			if (wr_cfg) begin
				config_q <= reg_wdata;
			end
		end
	end

	wire [7:0] status_word = {4'h0, low_rdy_q, high_rdy_q, to_q, pdf_q};
	wire [7:0] rd_mux = (reg_addr == iww_pkg::ADDR_WDOG_CTRL) ? wdog_ctrl_q :
		(reg_addr == iww_pkg::ADDR_SYS_MODE) ? sys_mode_q :
		(reg_addr == iww_pkg::ADDR_STATUS) ? status_word :
		(reg_addr == iww_pkg::ADDR_WAKE_EN) ? 8'(wake_en_q) :
		(reg_addr == iww_pkg::ADDR_CONFIG) ? config_q : 8'h00;

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
			clk_ctl <= '{sys_clk_en: 1'b1, tbase_clk_en: 1'b1, sub_clk_en: 1'b1, cpu_halted: 1'b0, hold_state: 1'b0};
			full_reset <= 1'b0;
			pc_sp_reset <= 1'b0;
			irq_service <= '0;
			irq_pending <= '0;
			resume_next <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
			clk_ctl.sys_clk_en <= (state_d == iww_pkg::IWW_RUN) || (state_d == iww_pkg::IWW_IDLE_ON);
			clk_ctl.tbase_clk_en <= (state_d != iww_pkg::IWW_START) && (state_d == iww_pkg::IWW_RUN || idle_sel);
			clk_ctl.sub_clk_en <= 1'b1;
			clk_ctl.cpu_halted <= state_d != iww_pkg::IWW_RUN;
			clk_ctl.hold_state <= state_d != iww_pkg::IWW_RUN;
			full_reset <= ext_rst_fall;
			pc_sp_reset <= wdt_ovf && !ext_rst_fall;
			irq_service <= (in_idle && |irq_wake) ? (irq_wake & can_serve) : (running ? can_serve : '0);
			irq_pending <= irq_req & ~can_serve;
			resume_next <= in_idle && any_wake && !ext_rst_fall && !wdt_ovf;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_halt_sets_pdf: assert property (@(posedge mclk) disable iff (!rst_b)
		halt_go |=> pdf_q) else $error("halt did not set power-down flag");
	a_halt_clears_to: assert property (@(posedge mclk) disable iff (!rst_b)
		halt_go && !wdt_ovf |=> !to_q) else $error("halt did not clear timeout");
	a_clkoff_idle: assert property (@(posedge mclk) disable iff (!rst_b)
		halt_go && idle_sel && !sysclk_keep |=> !clk_ctl.sys_clk_en && clk_ctl.sub_clk_en)
		else $error("clock-off idle kept system clock");
	a_clkon_idle: assert property (@(posedge mclk) disable iff (!rst_b)
		halt_go && idle_sel && sysclk_keep |=> clk_ctl.sys_clk_en && clk_ctl.cpu_halted)
		else $error("clock-on idle stopped system clock");
	a_ovf_sets_to: assert property (@(posedge mclk) disable iff (!rst_b)
		wdt_ovf |=> to_q && pc_sp_reset == !$past(ext_rst_fall)) else $error("overflow missed timeout");
	a_soft_disable: assert property (@(posedge mclk) disable iff (!rst_b)
		!wdt_on |-> cfg_dis && soft_en == 4'b1010) else $error("watchdog off without both keys");
	a_stale_irq: assert property (@(posedge mclk) disable iff (!rst_b)
		halt_go ##1 (in_idle && !ext_rst_fall && !port_wake && !wdt_ovf && (irq_req & irq_armed_q) == '0)
		|=> !resume_next) else $error("stale interrupt woke device");
	a_port_wake: assert property (@(posedge mclk) disable iff (!rst_b)
		in_idle && port_wake && !ext_rst_fall && !wdt_ovf |=> resume_next) else $error("port wake lost");
	a_start_wait: assert property (@(posedge mclk) disable iff (!rst_b)
		state_q == iww_pkg::IWW_START && !high_rdy_q |=> state_q != iww_pkg::IWW_RUN)
		else $error("ran before oscillator ready");

	c_idle_off: cover property (@(posedge mclk) state_q == iww_pkg::IWW_IDLE_OFF ##1 state_q == iww_pkg::IWW_RUN);
	c_idle_on: cover property (@(posedge mclk) state_q == iww_pkg::IWW_IDLE_ON ##1 resume_next);
	c_wdt_wake: cover property (@(posedge mclk) in_idle && wdt_ovf);
	c_startup: cover property (@(posedge mclk) state_q == iww_pkg::IWW_START ##1 state_q == iww_pkg::IWW_RUN);
endmodule

// >>> rtl/iww_pkg.sv
// Package: constants and carriers for the idle, wake-up and watchdog control block
package iww_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_WDOG_CTRL = 4'h0;
	localparam logic [3:0] ADDR_SYS_MODE = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_WAKE_EN = 4'h3;
	localparam logic [3:0] ADDR_CONFIG = 4'h4;

	localparam logic [7:0] WDOG_CTRL_RST = 8'h7a;
	localparam logic [7:0] SYS_MODE_RST = 8'h00;
	localparam logic [7:0] WAKE_EN_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;

	// Field positions in watchdog_control
	localparam int SYSCLK_KEEP_BIT = 7;
	localparam int TSEL_LSB = 4;
	localparam int SOFT_EN_LSB = 0;
	localparam logic [3:0] SOFT_DISABLE_CODE = 4'b1010;

	// Field positions in system_mode_reg and config register
	localparam int IDLE_SEL_BIT = 0;
	localparam int CFG_WDT_DIS_BIT = 0;
	localparam int CFG_SRC_SUB_BIT = 1;
	localparam int CFG_TWO_CLR_BIT = 2;

	// Status bits
	localparam int ST_PDF_BIT = 0;
	localparam int ST_TO_BIT = 1;
	localparam int ST_HIGH_RDY_BIT = 2;
	localparam int ST_LOW_RDY_BIT = 3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int WDT_BASE_LOG2 = 8;
	localparam int SYS_DIV = 4;
	localparam int STARTUP_CYCLES = 1024;
	localparam int CNT_W = 16;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		IWW_RUN = 2'b00,
		IWW_IDLE_OFF = 2'b01,
		IWW_IDLE_ON = 2'b11,
		IWW_START = 2'b10
	} iww_state_e;

	typedef struct packed {
		logic halt;
		logic clr_single;
		logic clr_one;
		logic clr_two;
	} iww_cmd_s;

	typedef struct packed {
		logic sys_clk_en;
		logic tbase_clk_en;
		logic sub_clk_en;
		logic cpu_halted;
		logic hold_state;
	} iww_clk_s;

endpackage

// >>> rtl/iww_wdog_cnt.sv
// Watchdog counter with selectable overflow division
`timescale 1ns/1ps
module iww_wdog_cnt #(
	parameter int CW = iww_pkg::CNT_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Control
	input wire logic tick,
	input wire logic clear,
	input wire logic [2:0] tsel,
	// Result
	output logic ovf
);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [CW-1:0] limit;
	wire at_limit;

	assign limit = CW'((32'd1 << (iww_pkg::WDT_BASE_LOG2 + 32'(tsel))) - 32'd1);
	assign at_limit = (cnt_q == limit);
	assign cnt_d = clear ? '0 : (tick ? (at_limit ? '0 : cnt_q + CW'(1)) : cnt_q);

	// Restart on clear, overflow after 2^(8+code) ticks
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			ovf <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			ovf <= tick && at_limit && !clear;
		end
	end

	a_ovf_needs_limit: assert property (@(posedge mclk) disable iff (!rst_b)
		ovf |-> $past(at_limit) && $past(tick)) else $error("overflow without limit");
	a_clear_restarts: assert property (@(posedge mclk) disable iff (!rst_b)
		clear |=> cnt_q == '0) else $error("clear did not restart count");
endmodule

// >>> test/iww_core_model.sv
// Core model: issues instruction pulses and tracks stack use
`timescale 1ns/1ps
module iww_core_model #(
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Requests from bench
	input wire iww_pkg::iww_cmd_s req,
	// Device side
	input wire iww_pkg::iww_clk_s clk_ctl,
	input wire logic [3:0] irq_service,
	output iww_pkg::iww_cmd_s cmd,
	output logic stack_full
);
	logic [3:0] depth_q;
	// A halted core fetches nothing, so no instruction leaves it
	assign cmd = clk_ctl.cpu_halted ? '0 : req;
	assign stack_full = (depth_q >= DEPTH[3:0]);
	// Each cycle with any interrupt serviced takes one level; never popped, so the stack can fill
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			depth_q <= 4'h0;
		end else if (|irq_service && !stack_full) begin
			depth_q <= depth_q + 4'h1;
		end
	end
endmodule

// >>> test/iww_ctrl_tb.sv
// Testbench: idle entry, wake-up and watchdog control
`timescale 1ns/1ps
module iww_ctrl_tb;
	// ------
	// Signals
	// ------
	logic mclk, rst_b, wr, rd, dsr, sfull, st, bt, xrst_b, fr, psr, rn;
	logic [3:0] addr, irq_req, irq_en, isv, ipd;
	logic [7:0] wdata, rdata, pa, v, m;
	logic [31:0] seed, r;
	iww_pkg::iww_cmd_s req, cmd;
	iww_pkg::iww_clk_s clk_ctl;
	int failures, cmp_count, n, k, p, c, ovf_cnt, o;

	iww_ctrl u_iww_ctrl (.mclk(mclk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdata), .cmd(cmd), .deep_sleep_req(dsr), .irq_req(irq_req),
		.irq_enable(irq_en), .stack_full(sfull), .sys_tick(st), .sub_tick(bt), .high_osc_needed(dsr),
		.low_osc_needed(dsr), .porta_pin(pa), .ext_reset_pin_b(xrst_b), .clk_ctl(clk_ctl),
		.full_reset(fr), .pc_sp_reset(psr), .irq_service(isv), .irq_pending(ipd), .resume_next(rn));
	iww_core_model #(.DEPTH(8)) u_iww_core_model (.mclk(mclk), .rst_b(rst_b), .req(req),
		.clk_ctl(clk_ctl), .irq_service(isv), .cmd(cmd), .stack_full(sfull));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Overflow and reset events, counted so that absence can be checked
	always @(posedge mclk) begin
		if (psr === 1'b1 || fr === 1'b1) begin
			ovf_cnt <= ovf_cnt + 1;
		end
	end

	// ------
	// Tasks
	// ------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int per(input int code, input logic sys);
		return (1 << (8 + code)) * (sys ? 4 : 1);
	endfunction
	function automatic logic [4:0] exp_halt(input logic keep);
		return {keep, 4'hf};
	endfunction
	function automatic logic sig(input int s);
		case (s)
			0: return rn;
			1: return psr;
			2: return fr;
			4: return !clk_ctl.cpu_halted;
			default: return isv[0];
		endcase
	endfunction
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chk_clk(input string nm, input logic [4:0] e, input logic [4:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic issue(input iww_pkg::iww_cmd_s q);
		@(posedge mclk);
		req <= q;
		@(posedge mclk);
		req <= '0;
		#1;
	endtask
	task automatic wait_sig(input int s, input int lim);
		n = 0;
		while (sig(s) !== 1'b1 && n < lim) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= lim) begin
			failures++;
			$display("MISMATCH wait_%0d exp 1 got 0", s);
			close_out();
		end
	endtask
	task automatic pin_wake();
		pa <= ~m;
		wait_sig(0, 12);
		chk_bit("resumed", 1'b0, clk_ctl.cpu_halted);
		pa <= 8'hff;
	endtask
	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ------
	// Sequence
	// ------
	initial begin
		seed = 32'h02f2_9e8d;
		failures = 0;
		cmp_count = 0;
		ovf_cnt = 0;
		rst_b = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		req = '0;
		dsr = 1'b0;
		irq_req = 4'h0;
		irq_en = 4'h0;
		st = 1'b1;
		bt = 1'b1;
		pa = 8'hff;
		xrst_b = 1'b1;
		m = 8'h01;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		rd_reg(4'h0, v);
		chk_reg("wdog_ctrl", 8'h7a, v);
		rd_reg(4'h2, v);
		chk_reg("status", 8'h0c, v);
		wr_reg(4'hf, 8'h5a);
		rd_reg(4'hf, v);
		chk_reg("unmapped", 8'h00, v);
		wr_reg(4'h4, 8'h01);
		for (int i = 0; i < 4; i++) begin
			r = xs();
			wr_reg(4'h3, r[7:0]);
			rd_reg(4'h3, v);
			chk_reg("wake_en", r[7:0], v);
		end
		end_test("registers");
		r = xs();
		k = r[2:0];
		m = 8'h01 << k;
		wr_reg(4'h3, m);
		wr_reg(4'h1, 8'h01);
		wr_reg(4'h0, 8'h0a);
		issue(4'h8);
		chk_clk("idle_off", exp_halt(1'b0), clk_ctl);
		wr_reg(4'h3, 8'h00);
		rd_reg(4'h2, v);
		chk_reg("flags", 8'h01, v & 8'h03);
		pa <= ~(8'h01 << ((k + 1) % 8));
		cyc(6);
		chk_bit("masked_pin", 1'b1, clk_ctl.cpu_halted);
		pin_wake();
		rd_reg(4'h3, v);
		chk_reg("wake_en_held", m, v);
		end_test("idle_off");
		irq_en <= 4'h1;
		issue(4'h8);
		irq_req <= 4'h1;
		wait_sig(3, 12);
		chk_bit("irq_pend0", 1'b0, ipd[0]);
		irq_req <= 4'h0;
		irq_en <= 4'h0;
		cyc(2);
		issue(4'h8);
		irq_req <= 4'h2;
		wait_sig(0, 12);
		chk_bit("irq_pend1", 1'b1, ipd[1]);
		irq_en <= 4'h2;
		cyc(3);
		chk_bit("irq_late", 1'b1, isv[1]);
		irq_req <= 4'h4;
		irq_en <= 4'h0;
		cyc(2);
		issue(4'h8);
		irq_en <= 4'h4;
		cyc(8);
		chk_bit("stale_irq", 1'b1, clk_ctl.cpu_halted);
		pin_wake();
		irq_req <= 4'h0;
		irq_en <= 4'h0;
		end_test("interrupts");
		// Soft code 0101 with the disable option cleared keeps it running on the system clock
		wr_reg(4'h0, 8'h85);
		wr_reg(4'h4, 8'h00);
		issue(4'h8);
		chk_clk("idle_on", exp_halt(1'b1), clk_ctl);
		p = per(0, 1'b1);
		wait_sig(1, p + 16);
		chk_bit("ovf_sys", 1'b1, n >= p - 6 && n <= p + 6);
		rd_reg(4'h2, v);
		chk_reg("flags_to", 8'h03, v & 8'h03);
		wr_reg(4'h0, 8'h05);
		o = ovf_cnt;
		issue(4'h8);
		rd_reg(4'h2, v);
		chk_reg("to_cleared", 8'h01, v & 8'h03);
		cyc(1100);
		chk_bit("sys_wdt_stop", 1'b1, ovf_cnt == o);
		pin_wake();
		end_test("idle_on");
		r = xs();
		c = r % 3;
		p = per(c, 1'b0);
		wr_reg(4'h0, {1'b0, c[2:0], 4'h5});
		wr_reg(4'h4, 8'h02);
		issue(4'h8);
		wait_sig(1, p + 16);
		chk_bit("ovf_sub", 1'b1, n >= p - 3 && n <= p + 3);
		issue(4'h4);
		rd_reg(4'h2, v);
		chk_reg("clr_pdf", 8'h00, v & 8'h01);
		wr_reg(4'h4, 8'h06);
		o = ovf_cnt;
		for (int i = 0; i < 6; i++) begin
			issue(i % 2 ? 4'h1 : 4'h2);
			cyc(p / 2);
		end
		chk_bit("alt_clear", 1'b1, ovf_cnt == o);
		for (int i = 0; i < 3; i++) begin
			issue(4'h1);
			cyc(p / 2);
		end
		chk_bit("same_clear", 1'b1, ovf_cnt > o);
		end_test("watchdog");
		// Deep wake: core waits for the high crystal, then the low one counts
		wr_reg(4'h4, 8'h01);
		wr_reg(4'h0, 8'h0a);
		dsr <= 1'b1;
		issue(4'h8);
		pa <= ~m;
		wait_sig(0, 12);
		chk_bit("deep_wait", 1'b1, clk_ctl.cpu_halted);
		rd_reg(4'h2, v);
		chk_reg("osc_starting", 8'h00, v & 8'h0c);
		wait_sig(4, 1100);
		chk_bit("sst_high", 1'b1, n >= 1010 && n <= 1030);
		rd_reg(4'h2, v);
		chk_reg("low_counting", 8'h04, v & 8'h0c);
		cyc(1030);
		rd_reg(4'h2, v);
		chk_reg("low_ready", 8'h0c, v & 8'h0c);
		pa <= 8'hff;
		dsr <= 1'b0;
		end_test("startup");
		wr_reg(4'h4, 8'h01);
		wr_reg(4'h0, 8'h0a);
		issue(4'h8);
		xrst_b <= 1'b0;
		wait_sig(2, 12);
		chk_bit("ext_no_wdt", 1'b0, psr);
		xrst_b <= 1'b1;
		cyc(4);
		end_test("ext_reset");
		close_out();
	end
endmodule
